/* src/rcl_loader.sv */
// Reset-time configuration byte loader with APB status and guard registers
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/100ps
`include "rcl_defines.svh"

// What this block does
// - Configuration is set only after reset ends, from the two user bytes.
// - Top eight map bytes form the configuration array, not ordinary memory.
// - Low byte comes from the array base, high byte from the next address.
// - The upper six array bytes carry no configuration meaning.
// - Without on-chip code memory both bytes come over the external bus.
// - With on-chip code and select inactive, bytes come from on-chip storage.
// - Select input low makes an on-chip code part fetch externally.
// - Configuration picks a 16, 17 or 18 bit external address bus.
// - Configuration picks zero to three wait states for external cycles.
// - Configuration picks opcode mode, interrupt frame and region 00 mapping.
// - External array addresses are FFF8h, 1FFF8h or 3FFF8h per bus width.
// - Low byte bits 3:2 set address signals and strobe ranges.
// - Low byte bit 1 picks page or non-page mode and data port.
// - Low byte bits 6:5 general waits; high byte bits 2:1 region 01 waits.
module rcl_loader
    import rcl_pkg::*;
#(
    parameter int HAS_ONCHIP_CODE = 1
)
(
    input wire logic pclk, // System clock, 10 MHz
    input wire logic presetn, // Asynchronous reset, active low
    input wire logic clk_en, // Freezes all state while low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped offset
    input wire logic external_access_select_n, // Strap pin, low selects external
    output rcl_ext_s ext_bus, // External address and read strobe
    input wire logic [7:0] ext_data, // External data pins
    output rcl_nvm_s nvm_req, // On-chip store request
    input wire logic [7:0] nvm_data, // On-chip store data
    input wire logic nvm_valid, // On-chip store data valid
    input wire logic cpu_acc, // Core memory access strobe
    input wire logic [23:0] cpu_addr, // Core memory access address
    output logic cpu_hold, // Holds instruction execution
    output logic cfg_valid, // Configuration latched
    output rcl_cfg_s cfg, // Decoded configuration
    output logic [7:0] user_config_byte_low, // Raw low byte
    output logic [7:0] user_config_byte_high // Raw high byte
);

    // ----------------------------------------
    // Constants and checks
    // ----------------------------------------
    localparam int EXT_WAIT_INT = `RCL_EXT_ACC_CYC + `RCL_SYNC_CYC;
    localparam logic [3:0] EXT_WAIT = 4'(EXT_WAIT_INT);
    localparam logic [23:0] ARR_BASE = `RCL_ARRAY_BASE;
    localparam logic [23:0] ADDR_LO = `RCL_ADDR_LOW;
    localparam logic [23:0] ADDR_HI = `RCL_ADDR_HIGH;

    // The wait counter is four bits; a slower memory needs a wider one
    generate
        if (HAS_ONCHIP_CODE != 0 && HAS_ONCHIP_CODE != 1)
        begin : g_bad_variant
            $error("HAS_ONCHIP_CODE must be 0 or 1");
        end
        if (EXT_WAIT_INT > 15)
        begin : g_bad_wait
            $error("External access time too long for wait counter");
        end
        // Byte order and the guard compare both assume an aligned array
        if (ARR_BASE[2:0] != 3'h0 || ADDR_LO != ARR_BASE || ADDR_HI != ADDR_LO + 24'h1)
        begin : g_bad_array
            $error("Configuration array addresses are inconsistent");
        end
        // Every field must sit inside its byte
        if (`RCL_LO_WSA_LSB > 6 || `RCL_LO_RD_LSB > 6 || `RCL_HI_WSB_LSB > 6 ||
            `RCL_HI_CODE_TO_DATA_MAP_N > 7 || `RCL_HI_INTERRUPT_FRAME_SELECT > 7 || `RCL_LO_PAGE > 7 || `RCL_HI_SRC > 7)
        begin : g_bad_field
            $error("Configuration field lies outside its byte");
        end
    endgenerate

    rcl_regs_s r;
    rcl_regs_s r_nxt;
    logic wr_acc;
    logic rd_setup;
    logic guard_hit;
    logic [23:0] fetch_addr;

    // ----------------------------------------
    // Field decode
    // ----------------------------------------

    // Turns the two raw bytes into the configuration the core sees
    // The six reserved array bytes are never fetched, so nothing here decodes them
    function automatic rcl_cfg_s decode(input logic [7:0] lo, input logic [7:0] hi);
        rcl_cfg_s c;
        c.addr_width_strobe_select = lo[`RCL_LO_RD_LSB +: 2];
        c.page_mode_n = lo[`RCL_LO_PAGE];
        c.wait_states_general_n = lo[`RCL_LO_WSA_LSB +: 2];
        c.wait_states_region1_n = hi[`RCL_HI_WSB_LSB +: 2];
        c.code_to_data_map_n = hi[`RCL_HI_CODE_TO_DATA_MAP_N];
        c.opcode_set_select = hi[`RCL_HI_SRC];
        c.interrupt_frame_select = hi[`RCL_HI_INTERRUPT_FRAME_SELECT];
        // Active-low wait bits: all ones means no wait state
        c.wait_count_general = ~lo[`RCL_LO_WSA_LSB +: 2];
        c.wait_count_region1 = ~hi[`RCL_HI_WSB_LSB +: 2];
        // Codes 10 and 11 both leave sixteen address lines
        case (lo[`RCL_LO_RD_LSB +: 2])
            `RCL_RD_18: c.ext_addr_bits = 5'h12;
            `RCL_RD_17: c.ext_addr_bits = 5'h11;
            default: c.ext_addr_bits = 5'h10;
        endcase
        return c;
    endfunction

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------

    // Write lands only at the completing edge of the access phase
    assign wr_acc = psel & penable & pwrite & clk_en;
    // Read data is prepared in the setup cycle so it comes from flops
    // Direction is ignored here, so unmapped writes raise the error as well
    assign rd_setup = psel & ~penable;
    // Any core touch of the eight top locations, whatever the offset
    // Only the core port is watched; the loader's own fetch is no violation
    assign guard_hit = cpu_acc & (cpu_addr[23:3] == ARR_BASE[23:3]);
    // The high byte sits one above the low byte
    assign fetch_addr = r.hi ? ADDR_HI : ADDR_LO;

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------

    // Sequencer, synchronisers, guard and APB registers
    always_comb
    begin
        r_nxt = r;
        r_nxt.nvm.rd = 1'b0;

        // Three-stage synchronisers for the strap and the data pins
        r_nxt.ea_s1 = external_access_select_n;
        r_nxt.ea_s2 = r.ea_s1;
        r_nxt.ea_s3 = r.ea_s2;
        r_nxt.dat_s1 = ext_data;
        r_nxt.dat_s2 = r.dat_s1;
        r_nxt.dat_s3 = r.dat_s2;

        case (r.state)
            // Wait out the synchroniser, then latch the strap once
            RCL_ST_STRAP:
            begin
                if (r.cnt != `RCL_STRAP_SETTLE)
                begin
                    r_nxt.cnt = r.cnt + 4'h1;
                end
                else if (r.ea_s2 == r.ea_s3)
                begin
                    // Stages agree, so the pin has settled; it is not looked at again
                    r_nxt.ea_latched = r.ea_s3;
                    // Parts without code memory always fetch outside
                    r_nxt.ext_src = (HAS_ONCHIP_CODE == 0) | ~r.ea_s3;
                    r_nxt.cnt = 4'h0;
                    r_nxt.hi = 1'b0;
                    r_nxt.state = RCL_ST_ISSUE;
                end
            end

            // Present one array address to the chosen source
            RCL_ST_ISSUE:
            begin
                r_nxt.cnt = 4'h0;
                if (r.ext_src)
                begin
                    // Low 18 bits of the internal address go out on all 18 lines;
                    // a narrower memory simply ignores the upper ones
                    r_nxt.ext.addr = fetch_addr[17:0];
                    r_nxt.ext.psen_n = 1'b0;
                end
                else
                begin
                    r_nxt.nvm.addr = fetch_addr;
                    r_nxt.nvm.rd = 1'b1;
                end
                r_nxt.state = RCL_ST_WAIT;
            end

            // Collect the byte, external by elapsed time, on-chip by valid
            RCL_ST_WAIT:
            begin
                if (r.ext_src)
                begin
                    // Counting first means the byte has stood on the pins
                    // through the whole synchroniser before it is taken
                    if (r.cnt != EXT_WAIT)
                    begin
                        r_nxt.cnt = r.cnt + 4'h1;
                    end
                    else if (r.dat_s2 == r.dat_s3)
                    begin
                        r_nxt.ext.psen_n = 1'b1;
                        if (r.hi)
                        begin
                            r_nxt.byte_hi = r.dat_s3;
                        end
                        else
                        begin
                            r_nxt.byte_lo = r.dat_s3;
                        end
                        r_nxt.hi = 1'b1;
                        r_nxt.state = r.hi ? RCL_ST_DONE : RCL_ST_ISSUE;
                    end
                end
                // The store answers in its own time; a dead store holds the core
                else if (nvm_valid)
                begin
                    if (r.hi)
                    begin
                        r_nxt.byte_hi = nvm_data;
                    end
                    else
                    begin
                        r_nxt.byte_lo = nvm_data;
                    end
                    r_nxt.hi = 1'b1;
                    r_nxt.state = r.hi ? RCL_ST_DONE : RCL_ST_ISSUE;
                end
            end

            // Decode once and release the core; nothing reloads before reset
            RCL_ST_DONE:
            begin
                if (!r.valid)
                begin
                    r_nxt.cfg = decode(r.byte_lo, r.byte_hi);
                    r_nxt.valid = 1'b1;
                end
                r_nxt.hold = 1'b0;
                // Park the bus so the array address does not linger on the pins
                r_nxt.ext.addr = 18'h0;
            end

            default:
            begin
                r_nxt.state = RCL_ST_STRAP;
                r_nxt.cnt = 4'h0;
            end
        endcase

        // Guard enable is software writable
        if (wr_acc && paddr == `RCL_OFS_GUARD_CTRL)
        begin
            r_nxt.guard_en = pwdata[0];
        end

        // Sticky violation flag; a new hit beats a clear in the same cycle
        r_nxt.guard_viol = r.guard_viol;
        if (wr_acc && paddr == `RCL_OFS_GUARD_STAT && pwdata[0])
        begin
            r_nxt.guard_viol = 1'b0;
        end
        if (r.guard_en && guard_hit)
        begin
            r_nxt.guard_viol = 1'b1;
        end

        // Read data and error captured in the setup cycle
        if (rd_setup)
        begin
            r_nxt.prdata = 32'h0;
            r_nxt.pslverr = 1'b0;
            case (paddr)
                `RCL_OFS_STATUS:
                begin
                    r_nxt.prdata[`RCL_ST_VALID] = r.valid;
                    r_nxt.prdata[`RCL_ST_EXT] = r.ext_src;
                    r_nxt.prdata[`RCL_ST_EA] = r.ea_latched;
                end
                `RCL_OFS_CONFIG:
                begin
                    r_nxt.prdata[15:0] = {r.byte_hi, r.byte_lo};
                end
                `RCL_OFS_GUARD_CTRL:
                begin
                    r_nxt.prdata[0] = r.guard_en;
                end
                `RCL_OFS_GUARD_STAT:
                begin
                    r_nxt.prdata[0] = r.guard_viol;
                end
                default:
                begin
                    r_nxt.pslverr = 1'b1;
                end
            endcase
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------

    // Unprogrammed bytes read as all ones, the no-wait-state, 16-bit-address setting
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r <= '0;
            r.hold <= 1'b1;
            r.ext.psen_n <= 1'b1;
            r.ea_latched <= 1'b1;
            r.byte_lo <= `RCL_CFG_RST;
            r.byte_hi <= `RCL_CFG_RST;
        end
        else if (clk_en)
        begin
            // Low enable freezes everything, synchronisers included
            r <= r_nxt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------

    // No wait states on the bus, but a frozen block never completes
    assign pready = clk_en;
    assign prdata = r.prdata;
    assign pslverr = r.pslverr & psel & penable;

    // Fetch requests toward the two byte sources
    assign ext_bus = r.ext;
    assign nvm_req = r.nvm;

    // Configuration toward the core, all from flops and steady until reset
    assign cpu_hold = r.hold;
    assign cfg_valid = r.valid;
    assign cfg = r.cfg;
    assign user_config_byte_low = r.byte_lo;
    assign user_config_byte_high = r.byte_hi;

endmodule // rcl_loader

/* src/rcl_defines.svh */
// Offsets, field positions, reset values and timing counts of the config loader
`ifndef RCL_DEFINES_SVH
`define RCL_DEFINES_SVH

// ----------------------------------------
// Configuration array in the memory map
// ----------------------------------------
`define RCL_ARRAY_BASE 24'hFFFFF8
`define RCL_ADDR_LOW 24'hFFFFF8
`define RCL_ADDR_HIGH 24'hFFFFF9
`define RCL_CFG_RST 8'hFF

// ----------------------------------------
// Field positions, low byte
// ----------------------------------------
`define RCL_LO_PAGE 1
`define RCL_LO_RD_LSB 2
`define RCL_LO_WSA_LSB 5

// ----------------------------------------
// Field positions, high byte
// ----------------------------------------
`define RCL_HI_SRC 0
`define RCL_HI_WSB_LSB 1
`define RCL_HI_INTERRUPT_FRAME_SELECT 4
`define RCL_HI_CODE_TO_DATA_MAP_N 5

// ----------------------------------------
// Address width codes
// ----------------------------------------
`define RCL_RD_18 2'h0
`define RCL_RD_17 2'h1

// ----------------------------------------
// Timing
// ----------------------------------------
`define RCL_CLK_NS 100
`define RCL_EXT_ACC_NS 300
`define RCL_EXT_ACC_CYC ((`RCL_EXT_ACC_NS + `RCL_CLK_NS - 1) / `RCL_CLK_NS)
`define RCL_SYNC_CYC 3
`define RCL_STRAP_SETTLE 4'h3

// ----------------------------------------
// APB register offsets and bits
// ----------------------------------------
`define RCL_OFS_STATUS 12'h000
`define RCL_OFS_CONFIG 12'h004
`define RCL_OFS_GUARD_CTRL 12'h008
`define RCL_OFS_GUARD_STAT 12'h00C
`define RCL_ST_VALID 0
`define RCL_ST_EXT 1
`define RCL_ST_EA 2

`endif

/* src/rcl_pkg.sv */
// Types shared by the reset configuration loader
package rcl_pkg;

    // Fetch sequencer states
    typedef enum logic [2:0] {
        RCL_ST_STRAP,
        RCL_ST_ISSUE,
        RCL_ST_WAIT,
        RCL_ST_DONE
    } rcl_state_e;

    // Decoded configuration handed to the core and bus unit
    typedef struct packed {
        logic [1:0] addr_width_strobe_select;
        logic page_mode_n;
        logic [1:0] wait_states_general_n;
        logic [1:0] wait_states_region1_n;
        logic code_to_data_map_n;
        logic opcode_set_select;
        logic interrupt_frame_select;
        logic [4:0] ext_addr_bits;
        logic [1:0] wait_count_general;
        logic [1:0] wait_count_region1;
    } rcl_cfg_s;

    // External code bus driven during the fetch
    typedef struct packed {
        logic [17:0] addr;
        logic psen_n;
    } rcl_ext_s;

    // On-chip non-volatile store request
    typedef struct packed {
        logic rd;
        logic [23:0] addr;
    } rcl_nvm_s;

    // All state of the loader
    typedef struct packed {
        rcl_state_e state;
        logic hi;
        logic [3:0] cnt;
        logic ea_s1;
        logic ea_s2;
        logic ea_s3;
        logic [7:0] dat_s1;
        logic [7:0] dat_s2;
        logic [7:0] dat_s3;
        logic ea_latched;
        logic ext_src;
        logic [7:0] byte_lo;
        logic [7:0] byte_hi;
        rcl_cfg_s cfg;
        logic valid;
        logic hold;
        rcl_ext_s ext;
        rcl_nvm_s nvm;
        logic guard_en;
        logic guard_viol;
        logic [31:0] prdata;
        logic pslverr;
    } rcl_regs_s;

endpackage

/* verif/rcl_properties.sv */
// Concurrent checks on the configuration loader ports
`timescale 1ns/100ps
module rcl_properties
    import rcl_pkg::*;
(
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire rcl_ext_s ext_bus, // Fetch bus
    input wire rcl_nvm_s nvm_req, // Store request
    input wire logic cpu_hold, // Core hold
    input wire logic cfg_valid, // Config latched
    input wire rcl_cfg_s cfg, // Decoded config
    input wire logic [7:0] user_config_byte_low, // Low byte
    input wire logic [7:0] user_config_byte_high // High byte
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire [7:0] lo = user_config_byte_low;
    wire [7:0] hi = user_config_byte_high;
    logic psen_q_r;
    logic n_strb_r;

    // ----------------------------------------
    // Fetch parity: even fetches want the low byte
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            psen_q_r <= 1'h1;
            n_strb_r <= 1'h0;
        end
        else
        begin
            psen_q_r <= ext_bus.psen_n;
            if ((ext_bus.psen_n && !psen_q_r) || nvm_req.rd)
                n_strb_r <= ~n_strb_r;
        end

    property p_hold; cpu_hold == !cfg_valid; endproperty
    a_hold: assert property (p_hold) else $error("core hold wrong");
    property p_sticky; cfg_valid |=> cfg_valid && $stable(cfg) && $stable({hi, lo}); endproperty
    a_sticky: assert property (p_sticky) else $error("config moved");
    property p_ext_addr; $fell(ext_bus.psen_n) |-> ext_bus.addr == {17'h1FFFC, n_strb_r}; endproperty
    a_ext_addr: assert property (p_ext_addr) else $error("fetch address wrong");
    property p_ext_hold; !ext_bus.psen_n |=> ext_bus.psen_n || $stable(ext_bus.addr); endproperty
    a_ext_hold: assert property (p_ext_hold) else $error("address moved");
    property p_ext_len; $fell(ext_bus.psen_n) |-> ##[6:16] ext_bus.psen_n; endproperty
    a_ext_len: assert property (p_ext_len) else $error("strobe too long");
    property p_nvm; nvm_req.rd |-> nvm_req.addr == {23'h7FFFFC, n_strb_r} && ext_bus.psen_n;
    endproperty
    a_nvm: assert property (p_nvm) else $error("store request wrong");
    property p_quiet; cfg_valid |-> ext_bus.psen_n && !nvm_req.rd; endproperty
    a_quiet: assert property (p_quiet) else $error("fetch after latch");
    property p_width; cfg_valid |-> cfg.addr_width_strobe_select == lo[3:2] &&
        cfg.ext_addr_bits == (lo[3:2] == 2'h0 ? 5'h12 : lo[3:2] == 2'h1 ? 5'h11 : 5'h10);
    endproperty
    a_width: assert property (p_width) else $error("bus width wrong");
    property p_wait; cfg_valid |-> cfg.wait_count_general == ~lo[6:5] &&
        cfg.wait_count_region1 == ~hi[2:1]; endproperty
    a_wait: assert property (p_wait) else $error("wait count wrong");
    property p_fields; cfg_valid |-> {cfg.page_mode_n, cfg.opcode_set_select,
        cfg.interrupt_frame_select, cfg.code_to_data_map_n} == {lo[1], hi[0], hi[4], hi[5]};
    endproperty
    a_fields: assert property (p_fields) else $error("mode field wrong");
    c_ext: cover property ($fell(ext_bus.psen_n));
    c_nvm: cover property (nvm_req.rd);
    c_done: cover property ($rose(cfg_valid));
endmodule // rcl_properties

/* verif/rcl_ext_mem.sv */
// External code memory holding the configuration array
`timescale 1ns/100ps
module rcl_ext_mem
    import rcl_pkg::*;
(
    input wire logic pclk, // Clock
    input wire rcl_ext_s ext_bus, // Fetch bus
    input wire logic [7:0] cfg_lo, // Array byte 0
    input wire logic [7:0] cfg_hi, // Array byte 1
    input wire logic slow, // Data one cycle late
    output logic [7:0] ext_data // Data pins
);
    logic [7:0] last_r = 8'h00;
    logic late_r = 1'h0;
    logic [7:0] word;
    wire drive = !ext_bus.psen_n && (late_r || !slow);

    // Array at the top of any width; reserved bytes read zero
    always_comb
        if (ext_bus.addr[15:3] != 13'h1FFF)
            word = 8'h5A;
        else if (ext_bus.addr[2:1] != 2'h0)
            word = 8'h00;
        else
            word = ext_bus.addr[0] ? cfg_hi : cfg_lo;

    // Released pins show the inverse, so stale data cannot pass
    always_ff @(posedge pclk)
    begin
        late_r <= !ext_bus.psen_n;
        if (drive)
            last_r <= word;
    end
    assign ext_data = drive ? word : ~last_r;
endmodule // rcl_ext_mem

/* verif/testbench.sv */
// Self-checking bench for the reset configuration loader
`timescale 1ns/100ps
`include "rcl_defines.svh"
module testbench
    import rcl_pkg::*;
;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic external_access_select_n = 1'h0;
    rcl_ext_s ext_bus;
    logic [7:0] ext_data;
    rcl_nvm_s nvm_req;
    logic [7:0] nvm_data = 8'h00;
    logic nvm_valid = 1'h0;
    logic cpu_acc = 1'h0;
    logic [23:0] cpu_addr = 24'h000000;
    logic cpu_hold;
    logic cfg_valid;
    rcl_cfg_s cfg;
    logic [7:0] user_config_byte_low;
    logic [7:0] user_config_byte_high;
    logic [7:0] mem_lo = 8'hFF;
    logic [7:0] mem_hi = 8'hFF;
    logic slow = 1'h0;
    logic [31:0] last_cw;
    int num_errors = 0;
    int n_tests = 0;

    initial
        forever #50 pclk = ~pclk;

    rcl_loader u_dut (.pclk, .presetn, .clk_en(1'h1), .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .external_access_select_n, .ext_bus, .ext_data,
        .nvm_req, .nvm_data, .nvm_valid, .cpu_acc, .cpu_addr, .cpu_hold, .cfg_valid, .cfg,
        .user_config_byte_low, .user_config_byte_high);
    rcl_ext_mem u_mem (.pclk, .ext_bus, .cfg_lo(mem_lo), .cfg_hi(mem_hi), .slow, .ext_data);

    // On-chip store: bit 7 flipped so the source shows in the bytes
    always @(posedge pclk)
    begin
        nvm_valid <= nvm_req.rd;
        nvm_data <= nvm_req.rd ? (nvm_req.addr[0] ? mem_hi : mem_lo) ^ 8'h80 : ~nvm_data;
    end

    task automatic complete_run;
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Bounded wait on a flag; running out ends the run
    task automatic wait_hi(ref logic f);
        int n;
        n = 0;
        while (f !== 1'h1 && n < 300)
        begin
            @(posedge pclk);
            n++;
        end
        if (n >= 300)
        begin
            chk("timeout", 32'h0, 32'h1);
            complete_run;
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        wait_hi(pready);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic boot(input logic ea, input logic [7:0] lo, input logic [7:0] hi,
        input logic sl);
        logic [7:0] s_lo;
        logic [7:0] s_hi;
        rcl_cfg_s e;
        logic [31:0] rd;
        logic err;
        presetn <= 1'h0;
        external_access_select_n <= ea;
        mem_lo <= lo;
        mem_hi <= hi;
        slow <= sl;
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        chk("hold early", 32'h1, cpu_hold);
        wait_hi(cfg_valid);
        @(posedge pclk);
        s_lo = lo ^ {ea, 7'h00};
        s_hi = hi ^ {ea, 7'h00};
        e = '{s_lo[3:2], s_lo[1], s_lo[6:5], s_hi[2:1], s_hi[5], s_hi[0], s_hi[4],
            s_lo[3:2] == 2'h0 ? 5'h12 : s_lo[3:2] == 2'h1 ? 5'h11 : 5'h10, ~s_lo[6:5], ~s_hi[2:1]};
        last_cw = {16'h0, s_hi, s_lo};
        chk("bytes", last_cw, {16'h0, user_config_byte_high, user_config_byte_low});
        chk("cfg", {13'h0, e}, {13'h0, cfg});
        chk("hold late", 32'h0, cpu_hold);
        apb(1'h0, `RCL_OFS_STATUS, 32'h0, rd, err);
        chk("status", {29'h0, ea, ~ea, 1'h1}, rd);
    endtask

    // Checked ten cycles after reset release, mid-fetch; nothing may be released early
    task automatic abort_fetch;
        presetn <= 1'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        repeat (10) @(posedge pclk);
        chk("mid valid", 32'h0, cfg_valid);
        chk("mid hold", 32'h1, cpu_hold);
    endtask

    task automatic regs;
        logic [31:0] rd;
        logic err;
        external_access_select_n <= ~external_access_select_n;
        mem_lo <= ~mem_lo;
        apb(1'h0, 12'h010, 32'h0, rd, err);
        chk("unmapped", 32'h1, err);
        apb(1'h1, 12'h010, 32'h1, rd, err);
        chk("unmapped write", 32'h1, err);
        apb(1'h0, `RCL_OFS_STATUS, 32'h0, rd, err);
        chk("status kept", 32'h5, rd);
        apb(1'h1, `RCL_OFS_CONFIG, 32'h0, rd, err);
        apb(1'h0, `RCL_OFS_CONFIG, 32'h0, rd, err);
        chk("config kept", last_cw, rd);
        apb(1'h1, `RCL_OFS_GUARD_CTRL, 32'h1, rd, err);
        apb(1'h0, `RCL_OFS_GUARD_CTRL, 32'h0, rd, err);
        chk("guard enable", 32'h1, rd);
        for (int k = 0; k < 3; k++)
        begin
            @(posedge pclk);
            cpu_acc <= 1'h1;
            cpu_addr <= k == 2 ? 24'hFFFFF8 : k ? 24'hFFFFF7 : 24'hFFFFF3;
            @(posedge pclk);
            cpu_acc <= 1'h0;
            apb(1'h0, `RCL_OFS_GUARD_STAT, 32'h0, rd, err);
            chk("guard", 32'(k == 2), rd);
        end
        apb(1'h1, `RCL_OFS_GUARD_STAT, 32'h1, rd, err);
        apb(1'h0, `RCL_OFS_GUARD_STAT, 32'h0, rd, err);
        chk("guard clear", 32'h0, rd);
    endtask

    // Every width, wait and mode code; last pass from on-chip store
    initial
    begin
        abort_fetch;
        for (int i = 0; i < 4; i++)
            boot(i == 3, {1'h1, i[1:0], 1'h1, i[1:0], i[0], 1'h1},
                {2'h3, i[1], ~i[0], 1'h1, ~i[1:0], i[0]}, i[0]);
        regs;
        complete_run;
    end
endmodule // testbench

bind rcl_loader rcl_properties u_props (.pclk, .presetn, .ext_bus, .nvm_req, .cpu_hold,
    .cfg_valid, .cfg, .user_config_byte_low, .user_config_byte_high);
